// >>> shared/oet_pkg.sv
// Package: register map, field layout and widths of the off-loadable event timer
//
// What this block does
// R1 - Eight timers share one main counter; each has its own comparator value.
// R2 - A timer raises its interrupt when its value equals the main counter.
// R3 - Timer 0 can run periodic as well as one-shot.
// R4 - Main counter only counts up; consecutive reads differ unless wrapped. In slow mode, reads between two slow edges return the same value.
// R5 - One counter tick lasts no longer than 100 ns.
// R6 - Enabled and on the fast clock, the 64-bit counter adds one per edge.
// R7 - With the crystal clock stopped, time is kept from the 32.768 kHz clock.
// R8 - Off-load is refused while any comparator is active.
// R9 - Power manager holds the off-load request and supplies 28-bit calibration.
// R10 - In slow mode the 82-bit counter adds the calibration per slow edge.
// R11 - Mode switches only on a slow rising edge; request and indication are fast.
// R12 - Entering slow mode loads count into upper 64 bits, low 18 bits cleared on the first entry only.
// R13 - Slow clock is double-synchronised; first edge after request parks the count.
// R14 - Next slow edge adds calibration to the parked value in the upper bits.
// R15 - Leaving slow mode reloads fast count from upper 64 bits and drops indication in the same cycle.
// R16 - Later reloads overwrite only the upper 64 bits; fraction bits are kept.
// R17 - Exit requested while parked waits for next edge; entry and exit share it.
// R18 - Legacy routing: timer 0 drives legacy IRQ0, advanced IRQ2; interval timer muted.
// R19 - Legacy routing: timer 1 drives IRQ8 on both; real-time clock interrupt muted.
// R20 - Legacy routing: timers 2, 3 use own routing; timers 4 to 7 have none.
// R21 - Legacy routing never blocks processor message delivery.
// R22 - Software masks interrupts before clearing legacy routing.
`default_nettype none
package oet_pkg;
	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int NUM_TIMERS = 8;
	localparam int CNT_W = 64;
	localparam int SLOW_W = 82;
	localparam int FRAC_W = 18;
	localparam int CAL_W = 28;
	localparam int ROUT_W = 5;
	localparam int PIC_LINES = 16;
	localparam int APIC_LINES = 24;
	localparam int ADDR_W = 8;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK_MAX_NS = 100;
	localparam int TICK_CYCLES = TICK_MAX_NS / CLK_PERIOD_NS;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CONFIG = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_COUNT_LO = 8'h08;
	localparam logic [7:0] OFF_COUNT_HI = 8'h0c;
	localparam logic [3:0] TMR_BASE_NIB = 4'h2;
	localparam logic [3:0] TMR_LAST_NIB = 4'h9;
	localparam logic [3:0] TOFF_CFG = 4'h0;
	localparam logic [3:0] TOFF_CMP_LO = 4'h4;
	localparam logic [3:0] TOFF_CMP_HI = 4'h8;
	// ------------------------------------------------------------
	// Fields
	// ------------------------------------------------------------
	localparam int CFG_ENABLE_BIT = 0;
	localparam int CFG_LEGACY_BIT = 1;
	localparam int STS_SLOW_BIT = 8;
	localparam int STS_PARKED_BIT = 9;
	localparam int TCFG_INT_EN_BIT = 0;
	localparam int TCFG_PERIODIC_BIT = 1;
	localparam int TCFG_PROCMSG_BIT = 2;
	localparam int TCFG_ROUT_LSB = 8;
	// ------------------------------------------------------------
	// Fixed legacy lines and bus response codes
	// ------------------------------------------------------------
	localparam int PIC_T0_LINE = 0;
	localparam int APIC_T0_LINE = 2;
	localparam int RTC_LINE = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {ST_FAST, ST_PARKED, ST_SLOW} oet_mode_t;
endpackage
`default_nettype wire

// >>> logic/oet_timer.sv
// Off-loadable event timer with AXI4-Lite register slave
`default_nettype none
module oet_timer
	import oet_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rtc_slow_clk,
	input wire logic offload_req,
	input wire logic [27:0] offload_cal,
	output logic slow_mode_active,
	input wire logic pit_irq,
	input wire logic rtc_irq,
	output logic [15:0] pic_irq,
	output logic [23:0] apic_irq,
	output logic [7:0] msg_irq
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		oet_mode_t mode;
		logic slow_ind;
		logic frac_kept;
		logic [CNT_W-1:0] count;
		logic [SLOW_W-1:0] slow;
		logic rtc_s1;
		logic rtc_s2;
		logic rtc_s3;
		logic enable;
		logic legacy;
		logic [NUM_TIMERS-1:0] int_en;
		logic [NUM_TIMERS-1:0] procmsg;
		logic [NUM_TIMERS-1:0] sts;
		logic t0_periodic;
		logic [NUM_TIMERS-1:0][ROUT_W-1:0] rout;
		logic [NUM_TIMERS-1:0][CNT_W-1:0] cmp;
		logic [CNT_W-1:0] period;
		logic [PIC_LINES-1:0] pic;
		logic [APIC_LINES-1:0] apic;
		logic [NUM_TIMERS-1:0] msg;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} oet_state_t;

	oet_state_t st_r;
	oet_state_t st_nxt;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// ------------------------------------------------------------
	// Handshakes
	// ------------------------------------------------------------
	// Address and data are taken together, so arrival order does not matter
	assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !st_r.bvalid;
	assign s_axi_wready = s_axi_awready;
	assign s_axi_arready = !st_r.rvalid;
	assign s_axi_bvalid = st_r.bvalid;
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_rvalid = st_r.rvalid;
	assign s_axi_rresp = st_r.rresp;
	assign s_axi_rdata = st_r.rdata;
	assign slow_mode_active = st_r.slow_ind;
	assign pic_irq = st_r.pic;
	assign apic_irq = st_r.apic;
	assign msg_irq = st_r.msg;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic rtc_rise;
		logic cmp_active;
		logic [SLOW_W-1:0] slow_sum;
		logic [CNT_W-1:0] cur_count;
		logic [NUM_TIMERS-1:0] hit;
		logic [NUM_TIMERS-1:0] level;
		logic [NUM_TIMERS-1:0] w1c;
		logic [2:0] ti;
		logic [7:0] wa;
		logic [7:0] ra;
		logic [31:0] old;
		logic [31:0] nv;
		rtc_rise = 1'b0;
		cmp_active = 1'b0;
		slow_sum = '0;
		cur_count = '0;
		hit = '0;
		level = '0;
		w1c = '0;
		ti = '0;
		wa = s_axi_awaddr;
		ra = s_axi_araddr;
		old = '0;
		nv = '0;
		st_nxt = st_r;

		// A slow clock already high at reset shows up as one early edge
		// Slow clock synchroniser; only stage two onward is looked at
		st_nxt.rtc_s1 = rtc_slow_clk; // [R13]
		st_nxt.rtc_s2 = st_r.rtc_s1;
		st_nxt.rtc_s3 = st_r.rtc_s2;
		rtc_rise = st_r.rtc_s2 && !st_r.rtc_s3; // [R11] [R13]
		cmp_active = st_r.enable && (|st_r.int_en);
		slow_sum = st_r.slow + {{(SLOW_W-CAL_W){1'b0}}, offload_cal}; // [R10]

		// One tick per 50 ns edge, within the 100 ns bound
		if (st_r.enable && st_r.mode == ST_FAST) begin
			st_nxt.count = st_r.count + 64'h1; // [R4] [R5] [R6]
		end

		// --------------------------------------------------------
		// Off-load sequence
		// --------------------------------------------------------
		case (st_r.mode)
			ST_FAST: begin
				// Busy comparators keep the crystal needed [R8]
				if (offload_req && !cmp_active && rtc_rise) begin // [R9]
					st_nxt.mode = ST_PARKED; // [R13]
					st_nxt.count = st_r.count;
					st_nxt.slow_ind = 1'b1; // [R11]
					st_nxt.slow[SLOW_W-1:FRAC_W] = st_r.count; // [R12] [R16]
					if (!st_r.frac_kept) begin
						st_nxt.slow[FRAC_W-1:0] = '0; // [R12]
						st_nxt.frac_kept = 1'b1;
					end
				end
			end
			ST_PARKED: begin
				if (rtc_rise) begin
					st_nxt.slow = slow_sum; // [R14]
					if (!offload_req) begin
						// Entry and exit complete on this one edge
						st_nxt.count = slow_sum[SLOW_W-1:FRAC_W]; // [R17]
						st_nxt.slow_ind = 1'b0;
						st_nxt.mode = ST_FAST;
					end else begin
						st_nxt.mode = ST_SLOW; // [R7]
					end
				end
			end
			ST_SLOW: begin
				if (rtc_rise) begin
					st_nxt.slow = slow_sum; // [R7] [R10]
					if (!offload_req) begin
						st_nxt.count = slow_sum[SLOW_W-1:FRAC_W]; // [R15]
						st_nxt.slow_ind = 1'b0; // [R15]
						st_nxt.mode = ST_FAST;
					end
				end
			end
			default: begin
				st_nxt.mode = ST_FAST;
			end
		endcase

		// --------------------------------------------------------
		// Comparators
		// --------------------------------------------------------
		// Slow mode shows the integer part of the slow count
		cur_count = st_r.slow_ind ? st_r.slow[SLOW_W-1:FRAC_W] : st_r.count;
		for (int n = 0; n < NUM_TIMERS; n++) begin
			hit[n] = st_r.enable && (st_r.cmp[n] == cur_count); // [R1] [R2]
		end
		// Count holds between slow edges, so one hit could last; no hits fire while parked or in slow mode
		if (st_r.mode != ST_FAST) begin
			hit = '0;
		end
		// Period is the last value written to the timer 0 comparator
		if (hit[0] && st_r.t0_periodic) begin
			st_nxt.cmp[0] = st_r.cmp[0] + st_r.period; // [R3]
		end

		// --------------------------------------------------------
		// Register writes
		// --------------------------------------------------------
		st_nxt.bvalid = st_r.bvalid && !s_axi_bready;
		if (s_axi_awready) begin
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = RESP_OKAY;
			if (wa == OFF_CONFIG) begin
				nv = merge({30'h0, st_r.legacy, st_r.enable}, s_axi_wdata, s_axi_wstrb);
				st_nxt.enable = nv[CFG_ENABLE_BIT];
				st_nxt.legacy = nv[CFG_LEGACY_BIT]; // [R18] [R19]
			end else if (wa == OFF_STATUS) begin
				nv = merge(32'h0, s_axi_wdata, s_axi_wstrb);
				w1c = nv[NUM_TIMERS-1:0];
			end else if (wa == OFF_COUNT_LO || wa == OFF_COUNT_HI) begin
				// Count is writable only while halted, else it could run backwards
				if (!st_r.enable && st_r.mode == ST_FAST) begin // [R4]
					old = wa[2] ? st_r.count[63:32] : st_r.count[31:0];
					nv = merge(old, s_axi_wdata, s_axi_wstrb);
					if (wa[2]) begin
						st_nxt.count[63:32] = nv;
					end else begin
						st_nxt.count[31:0] = nv;
					end
				end
			end else if (wa[7:4] >= TMR_BASE_NIB && wa[7:4] <= TMR_LAST_NIB &&
					wa[1:0] == 2'h0 && wa[3:0] != 4'hc) begin
				ti = 3'(wa[7:4] - TMR_BASE_NIB);
				if (wa[3:0] == TOFF_CFG) begin
					old = {19'h0, st_r.rout[ti], 5'h0, st_r.procmsg[ti],
						(ti == 3'h0) && st_r.t0_periodic, st_r.int_en[ti]};
					nv = merge(old, s_axi_wdata, s_axi_wstrb);
					st_nxt.int_en[ti] = nv[TCFG_INT_EN_BIT];
					st_nxt.procmsg[ti] = nv[TCFG_PROCMSG_BIT];
					st_nxt.rout[ti] = nv[TCFG_ROUT_LSB +: ROUT_W];
					if (ti == 3'h0) begin
						st_nxt.t0_periodic = nv[TCFG_PERIODIC_BIT]; // [R3]
					end
				end else if (wa[3:0] == TOFF_CMP_LO) begin
					nv = merge(st_r.cmp[ti][31:0], s_axi_wdata, s_axi_wstrb);
					st_nxt.cmp[ti][31:0] = nv; // [R1]
					if (ti == 3'h0) begin
						st_nxt.period[31:0] = nv;
					end
				end else begin
					nv = merge(st_r.cmp[ti][63:32], s_axi_wdata, s_axi_wstrb);
					st_nxt.cmp[ti][63:32] = nv;
					if (ti == 3'h0) begin
						st_nxt.period[63:32] = nv;
					end
				end
			end else begin
				st_nxt.bresp = RESP_SLVERR;
			end
		end

		// Fresh match beats a same-cycle clear
		st_nxt.sts = (st_r.sts & ~w1c) | hit; // [R2]

		// --------------------------------------------------------
		// Register reads
		// --------------------------------------------------------
		st_nxt.rvalid = st_r.rvalid && !s_axi_rready;
		if (s_axi_arvalid && s_axi_arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = RESP_OKAY;
			st_nxt.rdata = 32'h0;
			ti = 3'(ra[7:4] - TMR_BASE_NIB);
			if (ra == OFF_CONFIG) begin
				st_nxt.rdata = {30'h0, st_r.legacy, st_r.enable};
			end else if (ra == OFF_STATUS) begin
				st_nxt.rdata = {22'h0, st_r.mode == ST_PARKED, st_r.slow_ind, st_r.sts};
			end else if (ra == OFF_COUNT_LO) begin
				st_nxt.rdata = cur_count[31:0]; // [R4]
			end else if (ra == OFF_COUNT_HI) begin
				st_nxt.rdata = cur_count[63:32];
			end else if (ra[7:4] >= TMR_BASE_NIB && ra[7:4] <= TMR_LAST_NIB &&
					ra[3:0] == TOFF_CFG) begin
				st_nxt.rdata = {19'h0, st_r.rout[ti], 5'h0, st_r.procmsg[ti],
					(ti == 3'h0) && st_r.t0_periodic, st_r.int_en[ti]};
			end else if (ra[7:4] >= TMR_BASE_NIB && ra[7:4] <= TMR_LAST_NIB &&
					ra[3:0] == TOFF_CMP_LO) begin
				st_nxt.rdata = st_r.cmp[ti][31:0];
			end else if (ra[7:4] >= TMR_BASE_NIB && ra[7:4] <= TMR_LAST_NIB &&
					ra[3:0] == TOFF_CMP_HI) begin
				st_nxt.rdata = st_r.cmp[ti][63:32];
			end else begin
				st_nxt.rresp = RESP_SLVERR;
			end
		end

		// --------------------------------------------------------
		// Interrupt routing
		// --------------------------------------------------------
		level = st_r.sts & st_r.int_en;
		st_nxt.pic = '0;
		st_nxt.apic = '0;
		for (int n = 0; n < NUM_TIMERS; n++) begin
			// Message delivery wins and ignores legacy routing
			st_nxt.msg[n] = hit[n] && st_r.int_en[n] && st_r.procmsg[n]; // [R21]
			if (level[n] && !st_r.procmsg[n]) begin
				if (st_r.legacy && n == 0) begin
					st_nxt.pic[PIC_T0_LINE] = 1'b1; // [R18]
					st_nxt.apic[APIC_T0_LINE] = 1'b1; // [R18]
				end else if (st_r.legacy && n == 1) begin
					st_nxt.pic[RTC_LINE] = 1'b1; // [R19]
					st_nxt.apic[RTC_LINE] = 1'b1; // [R19]
				end else if (n < 4) begin
					// Routes past a controller's last line are dropped
					if (32'(st_r.rout[n]) < APIC_LINES) begin
						st_nxt.apic[st_r.rout[n]] = 1'b1; // [R20]
					end
					if (32'(st_r.rout[n]) < PIC_LINES) begin
						st_nxt.pic[4'(st_r.rout[n])] = 1'b1; // [R20]
					end
				end
			end
		end
		// Legacy sources muted while their lines are taken over
		if (!st_r.legacy) begin
			st_nxt.pic[PIC_T0_LINE] = st_nxt.pic[PIC_T0_LINE] | pit_irq; // [R18]
			st_nxt.apic[APIC_T0_LINE] = st_nxt.apic[APIC_T0_LINE] | pit_irq;
			st_nxt.pic[RTC_LINE] = st_nxt.pic[RTC_LINE] | rtc_irq; // [R19]
			st_nxt.apic[RTC_LINE] = st_nxt.apic[RTC_LINE] | rtc_irq;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule
`default_nettype wire

// >>> testbench/oet_pm_model.sv
// Power manager model: slow clock, off-load request and calibration
`default_nettype none
module oet_pm_model (
	input wire logic aclk,
	input wire logic want_offload,
	input wire logic [27:0] cal_val,
	output logic rtc_slow_clk,
	output logic offload_req,
	output logic [27:0] offload_cal
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// Slow clock
	// ------------------------------------------------------------
	// Sped up to 20 aclk per period so the run stays short
	initial begin
		rtc_slow_clk = 1'b0;
		#13;
		forever #500 rtc_slow_clk = ~rtc_slow_clk;
	end
	// Request held as a level for the whole stay, calibration beside it
	always @(posedge aclk) begin
		offload_req <= want_offload;
		offload_cal <= cal_val;
	end
endmodule
`default_nettype wire

// >>> testbench/oet_timer_sva.sv
// Checker for the event timer ports
`default_nettype none
module oet_timer_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic rtc_slow_clk,
	input wire logic offload_req,
	input wire logic slow_mode_active
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------------------
	// Handshake and mode checks
	// ------------------------------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_take;
		s_axi_awvalid && s_axi_wvalid && s_axi_awready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	wr_answer_a: assert property (wr_take |=> s_axi_bvalid)
		else $error("write response late");
	wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready
			|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
		else $error("read data late");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
			|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	rd_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
		else $error("read ready wrong");
	wr_ready_a: assert property (s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid))
		else $error("write ready wrong");
	slow_entry_a: assert property ($rose(slow_mode_active)
			|-> $past(offload_req) && $past(rtc_slow_clk))
		else $error("slow mode entered off edge");
	slow_exit_a: assert property ($fell(slow_mode_active)
			|-> !$past(offload_req) && $past(rtc_slow_clk))
		else $error("slow mode left off edge");
endmodule
bind oet_timer oet_timer_sva u_sva (.*);
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the off-loadable event timer
`default_nettype none
module tb;
	import oet_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic [1:0] e;} oet_row_t;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic rtc_slow_clk, offload_req, slow_mode_active, pit_irq, rtc_irq, want_offload;
	logic [7:0] s_axi_awaddr, s_axi_araddr, msg_irq;
	logic [31:0] s_axi_wdata, s_axi_rdata, a, b, c, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [27:0] offload_cal, cal_val;
	logic [15:0] pic_irq;
	logic [23:0] apic_irq;
	int n_fail = 0;
	int checks = 0;
	int k;
	oet_row_t rows[7] = '{
		'{8'h00, 32'h2, 32'h2, RESP_OKAY},
		'{8'h20, 32'h103, 32'h103, RESP_OKAY},
		'{8'h30, 32'h3, 32'h1, RESP_OKAY},
		'{8'h08, 32'h0, 32'h0, RESP_OKAY},
		'{8'h24, 32'h14, 32'h14, RESP_OKAY},
		'{8'h34, 32'h28, 32'h28, RESP_OKAY},
		'{8'h10, 32'h5, 32'h0, RESP_SLVERR}};
	oet_timer u_dut (.*);
	oet_pm_model u_pm (.*);
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("CHECK FAILED %0t saw %h want %h", $time, s, e);
		end
	endtask
	task automatic print_verdict;
		$display("mismatches %0d checks %0d", n_fail, checks);
		if (n_fail == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Address and data offered together, each released once taken; bready up early
	task automatic wr(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] r);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= dt;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && s_axi_awready === 1'b1) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready === 1'b1) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	// Three-edge span per call, so back-to-back reads are three counts apart
	task automatic rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		dt = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	always #25 aclk = ~aclk;
	initial begin
		repeat (3000) @(posedge aclk);
		n_fail++;
		print_verdict;
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, want_offload} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		pit_irq = 1'b1;
		rtc_irq = 1'b1;
		cal_val = 28'h140000;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(32'({s_axi_arready, s_axi_bvalid, slow_mode_active}), 32'h4);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w, rs);
			chk(32'(rs), 32'(rows[i].e));
			rd(rows[i].a, d, rs);
			chk(d, rows[i].r);
			chk(32'(rs), 32'(rows[i].e));
		end
		chk(32'({pic_irq[0], pic_irq[8], apic_irq[8]}), 32'h0);
		wr(8'h00, 32'h3, rs);
		for (k = 0; k < 60 && pic_irq[0] !== 1'b1; k++) @(posedge aclk);
		chk(32'({pic_irq[0], apic_irq[2]}), 32'h3);
		for (k = 0; k < 60 && pic_irq[8] !== 1'b1; k++) @(posedge aclk);
		chk(32'({pic_irq[8], apic_irq[8]}), 32'h3);
		rd(8'h08, a, rs);
		rd(8'h08, b, rs);
		rd(8'h08, c, rs);
		chk(b - a, 32'h3);
		chk(c - b, 32'h3);
		want_offload <= 1'b1;
		repeat (60) @(posedge aclk);
		chk(32'(slow_mode_active), 32'h0);
		wr(8'h20, 32'h0, rs);
		wr(8'h30, 32'h0, rs);
		for (k = 0; k < 60 && slow_mode_active !== 1'b1; k++) @(posedge aclk);
		chk(32'(slow_mode_active), 32'h1);
		rd(8'h08, a, rs);
		// Take edges exactly one slow period apart, so one calibration step lies between
		repeat (17) @(posedge aclk);
		rd(8'h08, b, rs);
		chk(b - a, 32'h5);
		want_offload <= 1'b0;
		for (k = 0; k < 60 && slow_mode_active !== 1'b0; k++) @(posedge aclk);
		chk(32'(slow_mode_active), 32'h0);
		rd(8'h08, c, rs);
		rd(8'h08, d, rs);
		chk(32'(c - b >= 32'h5), 32'h1);
		chk(d - c, 32'h3);
		// Timers already masked, so dropping legacy routing only frees the old sources
		wr(8'h00, 32'h1, rs);
		@(posedge aclk);
		chk(32'({pic_irq[0], apic_irq[2], pic_irq[8], apic_irq[8]}), 32'hf);
		// Legacy again: timer 2 on its own line, timer 5 unrouted, timer 1 by message
		wr(8'h00, 32'h0, rs);
		wr(8'h08, 32'h0, rs);
		wr(8'h0c, 32'h0, rs);
		wr(8'h30, 32'h5, rs);
		wr(8'h34, 32'h30, rs);
		wr(8'h40, 32'hb01, rs);
		wr(8'h44, 32'h30, rs);
		wr(8'h70, 32'hc01, rs);
		wr(8'h74, 32'h30, rs);
		wr(8'h04, 32'hff, rs);
		wr(8'h00, 32'h3, rs);
		for (k = 0; k < 80 && msg_irq[1] !== 1'b1; k++) @(posedge aclk);
		chk(32'(msg_irq), 32'h2);
		@(posedge aclk);
		chk(32'(msg_irq), 32'h0);
		chk(32'(pic_irq), 32'h800);
		chk(32'(apic_irq), 32'h800);
		print_verdict;
	end
endmodule
`default_nettype wire
